//--- verification/latu_chan_model.sv
// Channel model: user logic that drives the channels.
// Assumes the bench names the next word.
module latu_chan_model
(
  // In
  input wire logic i_ref_clk,
  input wire logic [7:0] i_next,
  // Out
  output logic [7:0] o_channels = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(negedge i_ref_clk)
    o_channels <= i_next;
endmodule : latu_chan_model

//--- verification/latu_trigger_unit_monitor.sv
// Checker on the trigger unit ports.
// Assumes one clock; bound at the foot.
module latu_trigger_unit_monitor
(
  // In
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_chain_len,
  input wire logic i_arm,
  input wire logic i_cancel,
  // Out
  input wire logic o_armed,
  input wire logic o_triggered,
  input wire logic o_capture,
  input wire logic [1:0] o_stage,
  input wire logic [2:0] o_pattern_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  trig_pulse_a: assert property (o_triggered |=> !o_triggered) else $error("long");
  trig_cause_a: assert property (
    o_triggered |-> $past(o_armed) && !o_armed && o_capture) else $error("stray");
  capture_hold_a: assert property (o_capture && !i_arm |=> o_capture) else $error("lost");
  cancel_idle_a: assert property (o_armed && i_cancel |=> !o_armed) else $error("cancel");
  stage_bound_a: assert property (
    o_armed |-> o_stage == 2'h0 || o_stage < i_chain_len) else $error("range");
  stage_step_a: assert property (
    o_armed && $past(o_armed) && o_stage != $past(o_stage) |-> o_stage == $past(o_stage) + 2'h1)
    else $error("skip");
  first_hit_a: assert property (o_triggered |-> o_pattern_hit[0]) else $error("hit");
  arm_clear_a: assert property (
    i_arm && !o_armed && !o_triggered && !i_cancel |=> o_armed && o_stage == 2'h0 && !o_pattern_hit)
    else $error("arm");
endmodule : latu_trigger_unit_monitor
bind latu_trigger_unit latu_trigger_unit_monitor i_mon
(
  .i_ref_clk, .i_reset_n, .i_chain_len, .i_arm, .i_cancel,
  .o_armed, .o_triggered, .o_capture, .o_stage, .o_pattern_hit
);

//--- verification/latu_trigger_unit_tb_top.sv
// Bench: arm and match tests on an 8-channel unit.
// Assumes the channel model feeds the channels.
module latu_trigger_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t mismatch", $time); end end
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_arm = 1'b0, i_cancel = 1'b0, f;
  logic o_armed, o_triggered, o_capture;
  logic [1:0] i_chain_len = 2'h1, i_arm_mode = 2'h0, o_stage;
  logic [2:0] i_or_mode = 3'h0, o_pattern_hit;
  logic [7:0] nx = 8'h00, i_trig_channels;
  logic [7:0] i_value_mask [3], i_edge_mask [3], i_dont_care_mask [3];
  int n_errors = 0, checked = 0;
  latu_trigger_unit #(.TRIGGER_WIDTH(8)) i_dut
  (
    .i_ref_clk, .i_reset_n, .i_trig_channels, .i_chain_len, .i_arm_mode, .i_or_mode,
    .i_value_mask, .i_edge_mask, .i_dont_care_mask, .i_arm, .i_cancel,
    .o_armed, .o_triggered, .o_capture, .o_stage, .o_pattern_hit
  );
  latu_chan_model i_chan (.i_ref_clk, .i_next(nx), .o_channels(i_trig_channels));
  initial
    forever #10 i_ref_clk = ~i_ref_clk;
  // Tests need some 170 cycles
  initial
  begin
    #50us;
    n_errors++;
    end_sim;
  end
  ////////////////////////////////////////
  task automatic end_sim;
    $display("%0d checks %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic p(input int i, input logic [7:0] d, e, v);
    i_dont_care_mask[i] = d;
    i_edge_mask[i] = e;
    i_value_mask[i] = v;
  endtask : p
  task automatic w(input logic e);
    f = 1'b0;
    repeat (8) @(negedge i_ref_clk) f |= o_triggered;
    `CHK(f, e)
  endtask : w
  // Cancel first so every test arms from rest
  task automatic t(input logic [1:0] l, input logic [2:0] o, input logic [7:0] c0, c1,
    input logic e);
    @(negedge i_ref_clk) {i_cancel, i_chain_len, i_or_mode} = {1'b1, l, o};
    nx <= c0;
    @(negedge i_ref_clk) i_cancel = 1'b0;
    @(negedge i_ref_clk) i_arm = 1'b1;
    @(negedge i_ref_clk) i_arm = 1'b0;
    w(e);
    nx <= c1;
    w(~e);
    $display("test done at %0t", $time);
  endtask : t
  initial
  begin
    for (int i = 0; i < 3; i++)
      p(i, 8'hFF, 8'h00, 8'h00);
    repeat (10) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    i_arm_mode = 2'h1;
    t(2'h3, 3'h0, 8'h00, 8'h00, 1'b1);
    `CHK(o_pattern_hit, 3'h7)
    `CHK(o_capture, 1'b1)
    i_arm_mode = 2'h0;
    p(0, 8'hFE, 8'h00, 8'h01);
    p(1, 8'h00, 8'h00, 8'h00);
    p(2, 8'h00, 8'h00, 8'h00);
    t(2'h1, 3'h0, 8'h00, 8'h01, 1'b0);
    p(0, 8'hFF, 8'h00, 8'h00);
    p(1, 8'h7F, 8'h80, 8'h80);
    t(2'h2, 3'h0, 8'h00, 8'h80, 1'b0);
    p(1, 8'h7F, 8'h80, 8'h00);
    t(2'h2, 3'h0, 8'h80, 8'h00, 1'b0);
    p(0, 8'hFC, 8'h00, 8'h03);
    t(2'h1, 3'h6, 8'h01, 8'h03, 1'b0);
    t(2'h1, 3'h1, 8'h00, 8'h02, 1'b0);
    p(0, 8'hFE, 8'h00, 8'h01);
    p(1, 8'hFD, 8'h00, 8'h02);
    p(2, 8'hFB, 8'h00, 8'h04);
    i_arm_mode = 2'h2;
    repeat (2)
      t(2'h3, 3'h0, 8'h06, 8'h07, 1'b0);
    end_sim;
  end
endmodule : latu_trigger_unit_tb_top

//--- verilog/latu_pkg.sv
// Constants for the logic analyzer trigger unit.
// Assumes a single user clock and configuration held steady while armed.
package latu_pkg;
  localparam int unsigned LATU_MAX_WIDTH = 40;
  localparam int unsigned LATU_MIN_WIDTH = 1;
  localparam int unsigned LATU_NUM_TRIG = 3;
  // Chain length encodings
  localparam logic [1:0] LATU_CHAIN_ONE = 2'h1;
  localparam logic [1:0] LATU_CHAIN_TWO = 2'h2;
  localparam logic [1:0] LATU_CHAIN_THREE = 2'h3;
  // Combining mode per pattern
  localparam logic LATU_MODE_AND = 1'h0;
  localparam logic LATU_MODE_OR = 1'h1;
  // Arming modes
  localparam logic [1:0] LATU_ARM_SINGLE = 2'h0;
  localparam logic [1:0] LATU_ARM_IMMEDIATE = 2'h1;
  localparam logic [1:0] LATU_ARM_REPEAT = 2'h2;
  // Reset values
  localparam logic [1:0] LATU_STAGE_RESET = 2'h0;
  // Controller state
  typedef enum logic [3:0]
  {
    LATU_IDLE = 4'h1,
    LATU_WAIT = 4'h2,
    LATU_FIRE = 4'h4,
    LATU_DONE = 4'h8
  } latu_state_type;
endpackage : latu_pkg

//--- verilog/latu_trigger_unit.sv
// Trigger unit: sequential pattern matcher over a trigger channel bus.
// Assumes trigger channels come from logic on i_ref_clk (no synchroniser)
// and that the debugger holds configuration stable while the unit is armed.
module latu_trigger_unit #(
  parameter int unsigned TRIGGER_WIDTH = latu_pkg::LATU_MAX_WIDTH
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Trigger channels from the design under test
  input wire logic [TRIGGER_WIDTH-1:0] i_trig_channels,
  // Configuration, one set of masks per pattern
  input wire logic [1:0] i_chain_len,
  input wire logic [1:0] i_arm_mode,
  input wire logic [2:0] i_or_mode,
  input wire logic [TRIGGER_WIDTH-1:0] i_value_mask [3],
  input wire logic [TRIGGER_WIDTH-1:0] i_edge_mask [3],
  input wire logic [TRIGGER_WIDTH-1:0] i_dont_care_mask [3],
  // Control
  input wire logic i_arm,
  input wire logic i_cancel,
  // Status
  output logic o_armed,
  output logic o_triggered,
  output logic o_capture,
  output logic [1:0] o_stage,
  output logic [2:0] o_pattern_hit
);
  import latu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection against last sample

  logic [TRIGGER_WIDTH-1:0] prev_reg;
  logic prev_valid_reg;
  latu_state_type state_reg;
  latu_state_type state_next;
  logic [1:0] stage_reg;
  logic [1:0] stage_next;
  logic [2:0] hit_reg;
  logic [2:0] hit;
  logic [1:0] last_stage;
  logic last_hit;
  logic cur_hit;
  logic arm_start;

  wire [TRIGGER_WIDTH-1:0] rise = i_trig_channels & ~prev_reg;
  wire [TRIGGER_WIDTH-1:0] fall = ~i_trig_channels & prev_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_reg <= '0;
      prev_valid_reg <= 1'h0;
    end
    else
    begin
      prev_reg <= i_trig_channels;
      prev_valid_reg <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pattern match
  // Edge bit set: value 1 means rising, 0 means falling; clear: level match.
  // Bit index equals channel index, so bit 0 is channel 0.

  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_pat
      wire [TRIGGER_WIDTH-1:0] edge_ok = (i_value_mask[t] & rise) |
        (~i_value_mask[t] & fall);
      wire [TRIGGER_WIDTH-1:0] lvl_ok = ~(i_value_mask[t] ^ i_trig_channels);
      // Edges need a valid previous sample; otherwise reset looks like an edge
      wire [TRIGGER_WIDTH-1:0] chan_ok =
        (i_edge_mask[t] & edge_ok & {TRIGGER_WIDTH{prev_valid_reg}}) |
        (~i_edge_mask[t] & lvl_ok);
      wire [TRIGGER_WIDTH-1:0] care = ~i_dont_care_mask[t];
      wire all_ok = &(chan_ok | ~care);
      // OR of nothing cared still matches, as an empty pattern must
      wire any_ok = (|(chan_ok & care)) | ~(|care);
      assign hit[t] = i_or_mode[t] ? any_ok : all_ok;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Chain length zero is treated as one
  assign last_stage = (i_chain_len == LATU_CHAIN_THREE) ? 2'h2 :
    (i_chain_len == LATU_CHAIN_TWO) ? 2'h1 : 2'h0;
  assign cur_hit = hit[stage_reg];
  assign last_hit = cur_hit && (stage_reg == last_stage);
  assign arm_start = i_arm && !i_cancel;

  always_comb
  begin
    state_next = state_reg;
    stage_next = stage_reg;
    case (state_reg)
      LATU_IDLE, LATU_DONE:
      begin
        if (arm_start)
        begin
          state_next = LATU_WAIT;
          stage_next = LATU_STAGE_RESET;
        end
      end
      LATU_WAIT:
      begin
        if (i_cancel)
        begin
          state_next = LATU_IDLE;
        end
        else if (last_hit)
        begin
          state_next = LATU_FIRE;
        end
        else if (cur_hit)
        begin
          // Next pattern is evaluated from the following clock
          stage_next = stage_reg + 2'h1;
        end
      end
      LATU_FIRE:
      begin
        // One trigger per arming; repetitive runs need a fresh arm
        state_next = LATU_DONE;
      end
      default:
      begin
        state_next = LATU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= LATU_IDLE;
      stage_reg <= LATU_STAGE_RESET;
      hit_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      stage_reg <= stage_next;
      hit_reg <= (arm_start && state_reg != LATU_WAIT) ? 3'h0 :
        hit_reg | ((state_reg == LATU_WAIT && cur_hit) ?
        (3'h1 << stage_reg) : 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  assign o_armed = (state_reg == LATU_WAIT);
  assign o_triggered = (state_reg == LATU_FIRE);
  assign o_capture = (state_reg == LATU_FIRE) || (state_reg == LATU_DONE);
  assign o_stage = stage_reg;
  assign o_pattern_hit = hit_reg;

  // Immediate mode is the host loading all don't-care; no special logic
  wire unused_cfg = ^i_arm_mode;

endmodule : latu_trigger_unit
